/* File: hdl/dsa_map.svh */
// timing counts, pin reset values and pin positions for the dual-sample host port
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH

`define DSA_CLK_NS        10
`define DSA_T_CONV_NS     400
`define DSA_T_ACQ_NS      250
`define DSA_T_SCLK_HALF_NS 20
`define DSA_T_ERR_NS      40

`define DSA_CONV_CYC ((`DSA_T_CONV_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_ACQ_CYC  ((`DSA_T_ACQ_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_HALF_CYC ((`DSA_T_SCLK_HALF_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_ERR_CYC  ((`DSA_T_ERR_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)

`define DSA_PIN_W    12
`define DSA_PIN_RST  12'h106
`define DSA_FIFO_D   4

`define DSA_SERIAL_RESULT_OUT_BIT 8
`define DSA_SCLK_BIT  9
`define DSA_SYNC_BIT  10
`define DSA_ERR_BIT   11

`endif

/* File: hdl/dsa_pkg.sv */
// types shared by the dual-sample host port
`default_nettype none
package dsa_pkg;
  typedef enum logic [2:0] {CV_IDLE, CV_CONV_A, CV_CONV_B, CV_LATCH, CV_ACQ} dsa_conv_t;
  typedef logic [15:0] dsa_sample_t;
  typedef logic [31:0] dsa_pair_t;
endpackage
`default_nettype wire

/* File: hdl/dsa_stream_if.sv */
// valid/ready stream between the host port and its result buffer
`timescale 1ns/1ps
`default_nettype none
interface dsa_stream_if #(parameter int W = 32);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  modport user_mp (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
  modport fifo_mp (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
endinterface // dsa_stream_if
`default_nettype wire

/* File: hdl/dsa_fifo.sv */
// result buffer: flip-flop fifo, depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module dsa_fifo
  import dsa_pkg::*;
#(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic     clk_i,
  input wire logic     rst_n_i,
  input wire logic     clk_en_i,
  dsa_stream_if.fifo_mp s
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         full;
  logic         empty;

  assign full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign s.in_ready  = !full;
  assign s.out_valid = !empty;
  assign s.out_data  = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (clk_en_i && s.in_valid && !full) begin
      mem_q[wp_q[AW-1:0]] <= s.in_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (clk_en_i) begin
      if (s.in_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (s.out_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // dsa_fifo
`default_nettype wire

/* File: hdl/dsa_host_port.sv */
// dual-sample converter host port: conversion sequencing and parallel/serial readout
`timescale 1ns/1ps
`default_nettype none
`include "dsa_map.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - serial internal-clock mode: bit 10 pin is frame sync
// - normal sync: high during read, low pulse mid
// - inverted sync: low during read, high pulse mid
// - slave read overrun: drop data, pulse error
// - parallel drives upper bits; serial floats 12-15
// - parallel mode: bits 10, 11 are data
// - busy from start until results latched
// - end-of-convert goes low per channel
// - outputs enabled only with select and read low
// - chip select gates external serial clock
// - reset pin aborts conversion, resets all but pin sync and edge detect
// - power-down finishes conversion, blocks new ones
// - start falling edge holds and starts conversion
// - impulse: start held low restarts after acquisition
// - 32-bit result shifted msb first, ordered
// - channel A always converted before B
// - pair select picks input pair
module dsa_host_port
  import dsa_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        reset_pin_i,
  input  wire logic        power_down_i,
  input  wire logic        impulse_mode_i,
  input  wire logic        convert_start_n_i,
  input  wire logic        input_pair_select_i,
  input  wire logic        channel_order_i,
  input  wire logic        port_format_select_i,
  input  wire logic        clock_source_select_i,
  input  wire logic        frame_sync_invert_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        read_n_i,
  input  wire logic        serial_clk_i,
  input  wire logic [15:0] result_a_i,
  input  wire logic [15:0] result_b_i,
  output logic             hold_o,
  output logic             pair_select_o,
  output logic             low_power_o,
  output logic             busy_o,
  output logic             end_of_convert_n_o,
  output logic [15:0]      data_o,
  output logic [15:0]      data_oe_o
);
  localparam logic [`DSA_PIN_W-1:0] PIN_RST = `DSA_PIN_RST;
  localparam logic [7:0] CONV_LAST = 8'(`DSA_CONV_CYC - 1);
  localparam logic [7:0] ACQ_LAST  = 8'(`DSA_ACQ_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(`DSA_HALF_CYC - 1);
  localparam logic [7:0] ERR_LEN   = 8'(`DSA_ERR_CYC);

  function automatic logic bus_on(input logic cs_n, input logic rd_n);
    return !cs_n && !rd_n;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [`DSA_PIN_W-1:0] pin_raw;
  logic [`DSA_PIN_W-1:0] pin_m_q;
  logic [`DSA_PIN_W-1:0] pin_s_q;

  assign pin_raw = {reset_pin_i, power_down_i, impulse_mode_i, convert_start_n_i,
                    input_pair_select_i, channel_order_i, port_format_select_i,
                    clock_source_select_i, frame_sync_invert_i, chip_select_n_i,
                    read_n_i, serial_clk_i};

  for (genvar g = 0; g < `DSA_PIN_W; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        pin_m_q[g] <= PIN_RST[g];
        pin_s_q[g] <= PIN_RST[g];
      end else if (clk_en_i) begin
        pin_m_q[g] <= pin_raw[g];
        pin_s_q[g] <= pin_m_q[g];
      end
    end
  end

  logic soft_rst;
  logic pd;
  logic impulse;
  logic convert_start_n_n;
  logic order_b_first;
  logic serial;
  logic ext_src;
  logic inv;
  logic cs_n;
  logic bus_en;
  logic sclk_s;

  assign soft_rst      = pin_s_q[11];
  assign pd            = pin_s_q[10];
  assign impulse       = pin_s_q[9];
  assign convert_start_n_n       = pin_s_q[8];
  assign order_b_first = pin_s_q[6];
  assign serial        = pin_s_q[5];
  assign ext_src       = pin_s_q[4];
  assign inv           = pin_s_q[3];
  assign cs_n          = pin_s_q[2];
  assign bus_en        = bus_on(pin_s_q[2], pin_s_q[1]);
  assign sclk_s        = pin_s_q[0];

  logic convert_start_n_prev_q;
  logic sclk_prev_q;
  logic start_fall;
  logic ext_rise;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      convert_start_n_prev_q <= 1'b1;
      sclk_prev_q  <= 1'b0;
    end else if (clk_en_i) begin
      convert_start_n_prev_q <= convert_start_n_n;
      sclk_prev_q  <= sclk_s;
    end
  end

  assign start_fall = convert_start_n_prev_q && !convert_start_n_n;
  assign ext_rise   = !sclk_prev_q && sclk_s && !cs_n;

  //////////////////////////////////////////////////////////////////////////////
  // result buffer
  logic        fifo_rst_n;
  logic        push;
  logic        discard;
  dsa_conv_t   cv_q;
  logic [7:0]  cnt_q;
  dsa_sample_t a_q;
  dsa_sample_t b_q;
  logic        have_q;
  logic        active_q;

  dsa_stream_if #(.W(32)) fifo_if ();

  assign fifo_rst_n        = rst_n_i && !soft_rst;
  assign fifo_if.in_data   = {a_q, b_q};
  assign fifo_if.in_valid  = (cv_q == CV_LATCH);
  assign fifo_if.out_ready = !have_q && !discard;
  assign push              = fifo_if.in_valid && fifo_if.in_ready;
  assign discard           = serial && ext_src && active_q && push;

  dsa_fifo #(.W(32), .D(`DSA_FIFO_D)) u_fifo (
    .clk_i    (clk_i),
    .rst_n_i  (fifo_rst_n),
    .clk_en_i (clk_en_i),
    .s        (fifo_if.fifo_mp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  logic busy_q;
  logic hold_q;
  logic eoc_n_q;
  logic pair_q;
  logic lp_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      cv_q    <= CV_IDLE;
      cnt_q   <= '0;
      busy_q  <= 1'b0;
      hold_q  <= 1'b0;
      eoc_n_q <= 1'b1;
      a_q     <= '0;
      b_q     <= '0;
    end else if (clk_en_i) begin
      eoc_n_q <= 1'b1;
      case (cv_q)
        CV_IDLE: begin
          if (start_fall && !pd) begin
            cv_q   <= CV_CONV_A;
            cnt_q  <= CONV_LAST;
            busy_q <= 1'b1;
            hold_q <= 1'b1;
          end
        end
        CV_CONV_A: begin
          if (cnt_q == 8'h00) begin
            a_q     <= result_a_i;
            eoc_n_q <= 1'b0;
            cv_q    <= CV_CONV_B;
            cnt_q   <= CONV_LAST;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CV_CONV_B: begin
          if (cnt_q == 8'h00) begin
            b_q     <= result_b_i;
            eoc_n_q <= 1'b0;
            cv_q    <= CV_LATCH;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CV_LATCH: begin
          // a full buffer keeps busy high: results are never overwritten
          if (push) begin
            busy_q <= 1'b0;
            hold_q <= 1'b0;
            cv_q   <= CV_ACQ;
            cnt_q  <= ACQ_LAST;
          end
        end
        CV_ACQ: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (impulse && !convert_start_n_n && !pd) begin
            cv_q   <= CV_CONV_A;
            cnt_q  <= CONV_LAST;
            busy_q <= 1'b1;
            hold_q <= 1'b1;
          end else begin
            cv_q <= CV_IDLE;
          end
        end
        default: begin
          cv_q <= CV_IDLE;
        end
      endcase
    end
  end

  // pair select only matters while tracking; the host keeps it still then
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      pair_q <= 1'b0;
      lp_q   <= 1'b0;
    end else if (clk_en_i) begin
      if (!hold_q) begin
        pair_q <= pin_s_q[7];
      end
      lp_q <= pd && (cv_q == CV_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // readout: parallel halves, internal-clock master, external-clock slave
  dsa_pair_t  shift_q;
  logic [5:0] bits_q;
  logic       sclk_q;
  logic [7:0] div_q;
  logic       en_prev_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      shift_q   <= '0;
      bits_q    <= '0;
      have_q    <= 1'b0;
      active_q  <= 1'b0;
      sclk_q    <= 1'b0;
      div_q     <= '0;
      en_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      en_prev_q <= bus_en;
      if (discard) begin
        have_q   <= 1'b0;
        active_q <= 1'b0;
        sclk_q   <= 1'b0;
        bits_q   <= '0;
      end else if (!have_q) begin
        if (fifo_if.out_valid) begin
          shift_q <= order_b_first ? {fifo_if.out_data[15:0], fifo_if.out_data[31:16]}
                                   : fifo_if.out_data;
          have_q  <= 1'b1;
          bits_q  <= '0;
        end
      end else if (!serial) begin
        if (en_prev_q && !bus_en) begin
          shift_q <= {shift_q[15:0], 16'h0000};
          bits_q  <= bits_q + 6'd16;
          if (bits_q == 6'd16) begin
            have_q <= 1'b0;
          end
        end
      end else if (!active_q) begin
        if (bus_en) begin
          active_q <= 1'b1;
          bits_q   <= '0;
          sclk_q   <= 1'b0;
          div_q    <= '0;
        end
      end else if (!ext_src) begin
        // the internal clock pauses while the bus is released
        if (bus_en) begin
          if (div_q == HALF_LAST) begin
            div_q  <= '0;
            sclk_q <= !sclk_q;
            if (sclk_q) begin
              shift_q <= {shift_q[30:0], 1'b0};
              bits_q  <= bits_q + 6'd1;
              if (bits_q == 6'd31) begin
                active_q <= 1'b0;
                have_q   <= 1'b0;
              end
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
      end else if (ext_rise) begin
        shift_q <= {shift_q[30:0], 1'b0};
        bits_q  <= bits_q + 6'd1;
        if (bits_q == 6'd31) begin
          active_q <= 1'b0;
          have_q   <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame sync, error pulse and pin drivers
  logic       sync_q;
  logic [7:0] err_cnt_q;
  logic [15:0] data_q;
  logic [15:0] oe_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      sync_q    <= 1'b0;
      err_cnt_q <= '0;
    end else if (clk_en_i) begin
      // mid-frame gap is the low half clock after the first channel
      sync_q <= (active_q && !(bits_q == 6'd16 && !sclk_q)) ^ inv;
      if (discard) begin
        err_cnt_q <= ERR_LEN;
      end else if (err_cnt_q != 8'h00) begin
        err_cnt_q <= err_cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      data_q <= '0;
      oe_q   <= '0;
    end else if (clk_en_i) begin
      if (!serial) begin
        data_q <= shift_q[31:16];
        oe_q   <= {16{bus_en}};
      end else begin
        data_q                 <= '0;
        data_q[`DSA_SERIAL_RESULT_OUT_BIT] <= shift_q[31];
        data_q[`DSA_SCLK_BIT]  <= sclk_q;
        data_q[`DSA_SYNC_BIT]  <= sync_q;
        data_q[`DSA_ERR_BIT]   <= (err_cnt_q != 8'h00);
        oe_q                   <= '0;
        oe_q[`DSA_SERIAL_RESULT_OUT_BIT]   <= bus_en;
        oe_q[`DSA_SCLK_BIT]    <= bus_en && !ext_src;
        oe_q[`DSA_SYNC_BIT]    <= bus_en && !ext_src;
        oe_q[`DSA_ERR_BIT]     <= bus_en && ext_src;
      end
    end
  end

  assign hold_o             = hold_q;
  assign pair_select_o      = pair_q;
  assign low_power_o        = lp_q;
  assign busy_o             = busy_q;
  assign end_of_convert_n_o = eoc_n_q;
  assign data_o             = data_q;
  assign data_oe_o          = oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || soft_rst || !clk_en_i);

  a_busy_start: assert property (cv_q == CV_IDLE && start_fall && !pd |=> busy_q && cv_q == CV_CONV_A)
    else $error("start edge did not begin a conversion");
  a_busy_fall: assert property ($fell(busy_q) |-> $past(cv_q) == CV_LATCH && $past(push))
    else $error("busy fell before results were latched");
  a_eoc_order: assert property (cv_q == CV_CONV_A && cnt_q == 8'h00 |=> !eoc_n_q && cv_q == CV_CONV_B)
    else $error("channel A end did not flag or move to B");
  a_oe_gated: assert property (|oe_q |-> $past(bus_en))
    else $error("output driven without select and read");
  a_upper_float: assert property ($past(serial) |-> oe_q[15:12] == 4'h0)
    else $error("upper bits driven in serial mode");
  a_par_drive: assert property ($past(!serial && bus_en) |-> oe_q == 16'hFFFF)
    else $error("parallel bits not driven");
  a_sync_frame: assert property ($rose(active_q) && $stable(inv) |=> sync_q != inv)
    else $error("frame sync not asserted at read start");
  a_err_pulse: assert property (discard |=> (err_cnt_q != 8'h00) [*4] ##1 (err_cnt_q == 8'h00 || $past(discard)))
    else $error("error pulse length wrong");
  a_pd_block: assert property (pd && cv_q == CV_IDLE |=> cv_q == CV_IDLE)
    else $error("conversion started in power-down");
  a_impulse_go: assert property (cv_q == CV_ACQ && cnt_q == 8'h00 && impulse && !convert_start_n_n && !pd
                                 |=> cv_q == CV_CONV_A && busy_q)
    else $error("held start did not restart conversion");
  a_ext_gate: assert property (active_q && serial && ext_src && cs_n && !discard |=> $stable(bits_q))
    else $error("serial clock shifted while deselected");

  property p_reset_idle;
    @(posedge clk_i) disable iff (!rst_n_i) (soft_rst && clk_en_i)
      |=> cv_q == CV_IDLE && !busy_q && err_cnt_q == 8'h00 && !active_q;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("reset pin did not idle the sequencers");

  c_push: cover property (push);
  c_master_done: cover property ($fell(active_q) && !ext_src);
  c_discard: cover property (discard);
  c_par_read: cover property (!serial && en_prev_q && !bus_en && have_q);
endmodule // dsa_host_port
`default_nettype wire

/* File: tb/dsa_host_model.sv */
// host-side model: drives select, read and the external serial clock, and captures results
`timescale 1ns/1ps
`default_nettype none
module dsa_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] oe_i,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             sclk_o
);
  // a released pin reads as the inverse of the value behind it, so undriven reads fail
  logic [15:0] pin;
  assign pin = data_i ^ ~oe_i;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  task automatic bus_on(input logic on);
    @(negedge clk_i);
    cs_n_o = ~on;
    rd_n_o = ~on;
  endtask
  task automatic read_par(output logic [31:0] w, output logic [15:0] oe);
    for (int i = 0; i < 2; i++) begin
      bus_on(1'b1);
      repeat (8) @(negedge clk_i);
      w = {w[15:0], pin};
      oe = oe_i;
      bus_on(1'b0);
      repeat (8) @(negedge clk_i);
    end
  endtask
  // n counts cycles of pulsed sync inside the frame; sync not active at the first rising clock adds 100
  task automatic read_master(input logic inv, output logic [31:0] w, output int n, output logic [15:0] oe);
    int   bits;
    int   t;
    logic prev;
    bits = 0;
    t = 0;
    n = 0;
    bus_on(1'b1);
    prev = pin[9];
    while (bits < 32 && t < 600) begin
      @(negedge clk_i);
      t++;
      if (bits > 0 && pin[10] === inv) n++;
      if (pin[9] === 1'b1 && prev === 1'b0) begin
        if (bits == 0) oe = oe_i;
        if (bits == 0 && pin[10] !== ~inv) n += 100;
        w = {w[30:0], pin[8]};
        bits++;
      end
      prev = pin[9];
    end
    // let the last falling edge finish the frame before the bus goes away
    repeat (8) @(negedge clk_i);
    bus_on(1'b0);
  endtask
  // clock stands low outside frames; pre edges arrive mid-frame while chip select is high
  task automatic read_slave(input int pre, input bit rel, output logic [31:0] w, output logic [15:0] oe);
    bus_on(1'b1);
    repeat (10) @(negedge clk_i);
    oe = oe_i;
    #3;
    for (int i = 0; i < (rel ? 32 : 4); i++) begin
      if (i == 16 && pre > 0) begin
        @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (pre) begin
          #62.5 sclk_o = 1'b1;
          #62.5 sclk_o = 1'b0;
        end
        @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (10) @(negedge clk_i);
        #3;
      end
      w = {w[30:0], pin[8]};
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    repeat (6) @(negedge clk_i);
    if (rel) bus_on(1'b0);
  endtask
endmodule // dsa_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the dual-sample host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dsa_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        clk_en = 1'b1;
  logic        rst_pin = 1'b0, pd = 1'b0, imp = 1'b0, start_n = 1'b1, pair = 1'b0;
  logic        order = 1'b0, fmt = 1'b0, ext = 1'b0, inv = 1'b0;
  logic        cs_n, rd_n, sclk, hold, psel, lowp, busy, eoc_n;
  dsa_sample_t ra = 16'h0000, rb = 16'h0000;
  logic [15:0] dq, doe, oe;
  logic [31:0] st = 32'h0001_72c2, w;
  int          error_cnt = 0, samples_checked = 0, err_cyc = 0, n, t;

  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) if (fmt && doe[11] === 1'b1 && dq[11] === 1'b1) err_cyc++;

  dsa_host_port dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .reset_pin_i(rst_pin),
    .power_down_i(pd), .impulse_mode_i(imp), .convert_start_n_i(start_n),
    .input_pair_select_i(pair), .channel_order_i(order), .port_format_select_i(fmt),
    .clock_source_select_i(ext), .frame_sync_invert_i(inv), .chip_select_n_i(cs_n),
    .read_n_i(rd_n), .serial_clk_i(sclk), .result_a_i(ra), .result_b_i(rb),
    .hold_o(hold), .pair_select_o(psel), .low_power_o(lowp), .busy_o(busy),
    .end_of_convert_n_o(eoc_n), .data_o(dq), .data_oe_o(doe)
  );
  dsa_host_model host (
    .clk_i(clk_i), .data_i(dq), .oe_i(doe), .cs_n_o(cs_n), .rd_n_o(rd_n), .sclk_o(sclk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] exp_word(input dsa_sample_t a, input dsa_sample_t b, input logic ord);
    return ord ? {b, a} : {a, b};
  endfunction
  function automatic logic [31:0] status();
    return {13'h0, busy, eoc_n, hold, doe};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // trace adds 1 per end-of-convert, 10 per cycle without hold, 100 if the pair leaks through
  task automatic convert(input dsa_sample_t a, input dsa_sample_t b, input bit keep, input bit pd_mid);
    int k;
    int eoc;
    int bc;
    @(negedge clk_i);
    ra = a;
    rb = b;
    start_n = 1'b0;
    k = 0;
    while (busy !== 1'b1 && k < 10) begin
      @(negedge clk_i);
      k++;
    end
    pd = pd_mid;
    pair = ~pair;
    eoc = 0;
    bc = 0;
    while (busy === 1'b1 && bc < 150) begin
      eoc += int'(eoc_n === 1'b0) + 10 * int'(hold !== 1'b1) + 100 * int'(psel !== ~pair);
      bc++;
      @(negedge clk_i);
    end
    if (!keep) start_n = 1'b1;
    chk("busy rise", 1, k < 10);
    chk("busy cycles", 81, bc);
    chk("conversion trace", 2, eoc);
    if (!keep) repeat (30) @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #900_000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("reset state", 32'h0002_0000, status());
    for (int i = 0; i < 4; i++) begin
      order = i[0];
      st = xs(st);
      convert(i == 0 ? 16'hffff : st[15:0], i == 0 ? 16'h0001 : st[31:16], 0, 0);
      host.read_par(w, oe);
      chk("parallel word", exp_word(ra, rb, order), w);
      chk("parallel enables", 32'h0000_ffff, {16'h0, oe});
      chk("bus released", 32'h0, {16'h0, doe});
    end
    fmt = 1'b1;
    for (int i = 0; i < 2; i++) begin
      inv = i[0];
      order = ~i[0];
      st = xs(st);
      convert(st[15:0], st[31:16], 0, 0);
      host.read_master(inv, w, n, oe);
      chk("master word", exp_word(ra, rb, order), w);
      chk("sync pulse cycles", 2, n);
      chk("master enables", 32'h0000_0700, {16'h0, oe});
    end
    ext = 1'b1;
    st = xs(st);
    convert(st[15:0], 16'h8000, 0, 0);
    host.read_slave(3, 1, w, oe);
    chk("slave word", exp_word(ra, rb, order), w);
    chk("slave enables", 32'h0000_0900, {16'h0, oe});
    st = xs(st);
    convert(st[15:0], st[31:16], 0, 1);
    repeat (5) @(negedge clk_i);
    chk("low power", 1, lowp);
    start_n = 1'b0;
    t = 0;
    repeat (100) @(negedge clk_i) t += int'(busy !== 1'b0);
    chk("start ignored", 0, t);
    start_n = 1'b1;
    pd = 1'b0;
    repeat (30) @(negedge clk_i);
    imp = 1'b1;
    convert(st[31:16], st[15:0], 1, 0);
    t = 0;
    while (busy !== 1'b1 && t < 40) begin
      @(negedge clk_i);
      t++;
    end
    chk("impulse restart", 1, t >= 24 && t <= 30);
    start_n = 1'b1;
    t = 0;
    while (busy === 1'b1 && t < 150) begin
      @(negedge clk_i);
      t++;
    end
    chk("impulse busy cycles", 81, t);
    imp = 1'b0;
    repeat (30) @(negedge clk_i);
    err_cyc = 0;
    host.read_slave(0, 0, w, oe);
    convert(st[15:0], st[31:16], 0, 0);
    chk("error pulse cycles", 4, err_cyc);
    host.bus_on(1'b0);
    start_n = 1'b0;
    repeat (30) @(negedge clk_i);
    rst_pin = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("reset pin abort", 32'h0002_0000, status());
    rst_pin = 1'b0;
    start_n = 1'b1;
    repeat (30) @(negedge clk_i);
    // freeze a running conversion: busy must outlast its normal length, then resume where it stopped
    start_n = 1'b0;
    repeat (20) @(negedge clk_i);
    clk_en = 1'b0;
    t = 0;
    repeat (100) @(negedge clk_i) t += int'(busy !== 1'b1);
    clk_en = 1'b1;
    chk("frozen busy", 0, t);
    t = 0;
    while (busy === 1'b1 && t < 150) begin
      @(negedge clk_i);
      t++;
    end
    chk("resumed busy cycles", 64, t);
    start_n = 1'b1;
    repeat (30) @(negedge clk_i);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
